// file: hw/sbg_top.sv
// Serial port baud generator with its AHB-Lite register slave.
module sbg_top (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             scl_o,
    output logic             scl_oe_o,
    output logic             reload_strobe_o,
    output logic             slew_ctrl_en_o,
    output logic             sample_at_end_o,
    output logic             clk_edge_sel_o,
    output logic             busy_o
);
    import sbg_pkg::*;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  reload;
        logic [7:0]  shbuf;
        logic        enable;
        logic        mode_i2c;
        logic        busy;
        logic [4:0]  halves;
        logic        scl;
        logic        wr_pend;
        logic [3:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        scl_oe;
        logic        strobe;
        logic        slew_en;
        logic        smp_end;
        logic        cke;
        logic        hresp;
    } sbg_state_t;

    sbg_state_t s_r;
    sbg_state_t s_nxt;
    logic       rollover;
    logic       take;
    logic       addr_hit;
    logic [3:0] addr_ofs;
    logic       wr_land;
    logic       start_ok;
    logic       half_done;
    logic       last_half;

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    // Runs only while an operation is in flight, parked on the reload otherwise
    sbg_counter u_counter (
        .clock_i        (clock_i),
        .resetn_i       (resetn_i),
        .run_i          (s_r.busy),
        .reload_value_i (s_r.reload),
        .rollover_o     (rollover)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Anything outside the four aligned words reads zero and drops writes
    assign take     = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;
    assign addr_ofs = {haddr_i[3:2], 2'b00};
    assign addr_hit = haddr_i[31:4] == 28'h0000000 && haddr_i[1:0] == 2'b00;
    assign wr_land  = s_r.wr_pend;

    // Read word of one register; unused bits stay zero
    function automatic logic [31:0] read_word(input sbg_state_t st, input logic [3:0] ofs);
        logic [31:0] word;
        word = 32'h0000_0000;
        unique case (ofs)
            STATUS_OFS: word[7:0] = {st.status[7:6], 6'h00};
            RELOAD_OFS: word[7:0] = st.reload;
            SHBUF_OFS:  word[7:0] = st.shbuf;
            CTRL_OFS:   word[2:0] = {st.busy, st.mode_i2c, st.enable};
            default: ;
        endcase
        return word;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock sequencing

    // A start needs the port enabled and no operation in flight
    assign start_ok  = s_r.enable && !s_r.busy;
    // Each rollover of the running counter closes one half period
    assign half_done = s_r.busy && rollover;
    assign last_half = s_r.halves == 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt         = s_r;
        s_nxt.wr_pend = 1'b0;

        // Data phase of a write lands here
        if (wr_land) begin
            unique case (s_r.wr_addr)
                STATUS_OFS: begin
                    s_nxt.status[STAT_SMP_BIT] = hwdata_i[STAT_SMP_BIT];
                    s_nxt.status[STAT_CKE_BIT] = hwdata_i[STAT_CKE_BIT];
                end
                RELOAD_OFS: s_nxt.reload = hwdata_i[7:0];
                SHBUF_OFS: begin
                    s_nxt.shbuf = hwdata_i[7:0];
                    if (start_ok) begin
                        s_nxt.busy   = 1'b1;
                        s_nxt.halves = HALVES_PER_OP;
                    end
                end
                CTRL_OFS: begin
                    s_nxt.enable   = hwdata_i[CTRL_EN_BIT];
                    s_nxt.mode_i2c = hwdata_i[CTRL_I2C_BIT];
                end
                default: ;
            endcase
        end

        // Each rollover is one half period of the serial clock
        if (half_done) begin
            s_nxt.scl    = ~s_r.scl;
            s_nxt.halves = s_r.halves - 5'h01;
            if (last_half) begin
                s_nxt.busy = 1'b0;
            end
        end
        // Clearing enable aborts at once; the clock keeps its level
        if (!s_nxt.enable) begin
            s_nxt.busy = 1'b0;
        end

        // Address phase: read from the updated copy, so back to back is coherent
        if (take) begin
            s_nxt.wr_pend = hwrite_i && addr_hit;
            s_nxt.wr_addr = addr_ofs;
            s_nxt.hrdata  = 32'h0000_0000;
            if (!hwrite_i && addr_hit) begin
                s_nxt.hrdata = read_word(s_nxt, addr_ofs);
            end
        end

        // Zero wait states and an OKAY answer on every transfer
        s_nxt.hreadyout = 1'b1;
        s_nxt.hresp     = 1'b0;

        // Open drain in I2C: drive only the low level, the pull-up makes the high
        if (s_nxt.mode_i2c) begin
            s_nxt.scl_oe = s_nxt.enable && !s_nxt.scl;
        end else begin
            s_nxt.scl_oe = s_nxt.enable;
        end
        s_nxt.strobe = half_done;

        // Status bit 7 means slew control in I2C and sample point in SPI
        if (s_nxt.mode_i2c) begin
            s_nxt.slew_en = !s_nxt.status[STAT_SMP_BIT];
            s_nxt.smp_end = 1'b0;
        end else begin
            s_nxt.slew_en = 1'b0;
            s_nxt.smp_end = s_nxt.status[STAT_SMP_BIT];
        end
        s_nxt.cke = s_nxt.status[STAT_CKE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r           <= '0;
            s_r.status    <= STATUS_RST;
            s_r.reload    <= RELOAD_RST;
            s_r.shbuf     <= SHBUF_RST;
            s_r.enable    <= CTRL_RST[CTRL_EN_BIT];
            s_r.mode_i2c  <= CTRL_RST[CTRL_I2C_BIT];
            s_r.busy      <= CTRL_RST[CTRL_BUSY_BIT];
            // Serial clock idles high, as a released I2C line does
            s_r.scl       <= 1'b1;
            s_r.hreadyout <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state flops

    assign hrdata_o        = s_r.hrdata;
    assign hreadyout_o     = s_r.hreadyout;
    assign hresp_o         = s_r.hresp;
    assign scl_o           = s_r.scl;
    assign scl_oe_o        = s_r.scl_oe;
    assign reload_strobe_o = s_r.strobe;
    assign slew_ctrl_en_o  = s_r.slew_en;
    assign sample_at_end_o = s_r.smp_end;
    assign clk_edge_sel_o  = s_r.cke;
    assign busy_o          = s_r.busy;

endmodule

// file: shared/sbg_pkg.sv
// Package for the serial port baud generator: register map, fields, timing.
package sbg_pkg;

    // Byte addresses of the word registers
    localparam logic [3:0] STATUS_OFS = 4'h0;
    localparam logic [3:0] RELOAD_OFS = 4'h4;
    localparam logic [3:0] SHBUF_OFS  = 4'h8;
    localparam logic [3:0] CTRL_OFS   = 4'hc;

    // Status register fields
    localparam int STAT_SMP_BIT = 7;
    localparam int STAT_CKE_BIT = 6;

    // Control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_I2C_BIT  = 1;
    localparam int CTRL_BUSY_BIT = 2;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] SHBUF_RST  = 8'h00;
    localparam logic [2:0] CTRL_RST   = 3'h0;

    // Counter steps once per this many system clocks, giving Fosc/(4(R+1))
    localparam logic [1:0] TICK_DIV   = 2'h2;
    // Half periods of the serial clock in one byte operation
    localparam logic [4:0] HALVES_PER_OP = 5'h10;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;

endpackage

// file: hw/sbg_counter.sv
// Reload down counter that paces the serial clock.
module sbg_counter (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       run_i,
    input  wire logic [7:0] reload_value_i,
    output logic            rollover_o
);
    import sbg_pkg::*;

    typedef struct packed {
        logic [1:0] prescale;
        logic [7:0] count;
    } sbg_cnt_state_t;

    sbg_cnt_state_t s_r;
    sbg_cnt_state_t s_nxt;
    logic           step;

    // One counter step per two system clocks gives Fosc/(4(R+1)) overall
    assign step = s_r.prescale == TICK_DIV - 2'h1;

    always_comb begin
        s_nxt = s_r;
        if (!run_i) begin
            // Parked with the reload preloaded so the first half is full length
            s_nxt.prescale = 2'h0;
            s_nxt.count    = reload_value_i;
        end else if (step) begin
            s_nxt.prescale = 2'h0;
            if (s_r.count == 8'h00) begin
                s_nxt.count = reload_value_i;
            end else begin
                s_nxt.count = s_r.count - 8'h01;
            end
        end else begin
            s_nxt.prescale = s_r.prescale + 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Not registered, so the caller's toggle lands exactly R+1 steps after a reload
    assign rollover_o = run_i && step && s_r.count == 8'h00;

endmodule

// file: tb/sbg_properties.sv
// Port assertions of the serial port baud generator.
module sbg_checker import sbg_pkg::*; (
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        scl_o,
    input wire logic        reload_strobe_o,
    input wire logic        busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr_rl_r;
    logic       wr_buf_r;
    logic [7:0] rl_r;
    logic [9:0] gap_r;
    logic [4:0] nstb_r;
    wire  [9:0] half = {1'b0, rl_r, 1'b0} + 10'h002;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Reload shadowed from bus writes; counters clear while idle, so no reset needed
    always_ff @(posedge clock_i) begin
        wr_rl_r  <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == 32'(RELOAD_OFS);
        wr_buf_r <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == 32'(SHBUF_OFS);
        if (wr_rl_r) rl_r <= hwdata_i[7:0];
        gap_r    <= !busy_o ? 10'h000 : reload_strobe_o ? 10'h001 : gap_r + 10'h001;
        nstb_r   <= !busy_o ? 5'h00 : nstb_r + {4'h0, reload_strobe_o};
    end
    start_write_a: assert property ($rose(busy_o) |-> $past(wr_buf_r)) else $error("start");
    idle_hold_a: assert property (!busy_o |=> $stable(scl_o)) else $error("idle scl");
    op_length_a: assert property (reload_strobe_o |-> (nstb_r == 5'h0f) == !busy_o)
        else $error("op length");
    strobe_toggle_a: assert property (reload_strobe_o == (scl_o != $past(scl_o)))
        else $error("toggle");
    strobe_busy_a: assert property (reload_strobe_o |-> $past(busy_o)) else $error("idle");
    half_period_a: assert property (reload_strobe_o |-> gap_r == half) else $error("half");
    half_bound_a: assert property (busy_o |-> gap_r <= half) else $error("late");
    upper_zero_a: assert property (hrdata_o[31:8] == 24'h0) else $error("upper");
    cover property ($fell(busy_o) && reload_strobe_o);
    cover property ($fell(busy_o) && !reload_strobe_o);
    cover property (wr_rl_r);
endmodule
bind sbg_top sbg_checker i_sbg_checker (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hwdata_i, .hrdata_o, .scl_o, .reload_strobe_o, .busy_o);

// file: tb/sbg_slave_model.sv
// Serial slave model: counts rises of the shared clock line.
module sbg_slave_model (
    input  wire logic scl_line_i,
    output int        rises_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Never stretches the clock, so the master is never held back
    always @(posedge scl_line_i) rises_o <= rises_o + 1;
endmodule

// file: tb/tb.sv
// Self-checking bench of the serial port baud generator.
module tb import sbg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, q;
    logic        hreadyout_o, scl_o, scl_oe_o, reload_strobe_o, lvl;
    logic        slew_ctrl_en_o, sample_at_end_o, clk_edge_sel_o, busy_o;
    int          bad_count = 0, n_compared = 0, cycles = 0, seed = 32'hc62c;
    int          n, r, base, rises;
    wire logic   scl_line = scl_oe_o ? scl_o : 1'b1;
    always #25 clock_i = ~clock_i;
    sbg_top i_sbg_top (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o(), .scl_o, .scl_oe_o, .reload_strobe_o, .slew_ctrl_en_o,
        .sample_at_end_o, .clk_edge_sel_o, .busy_o);
    sbg_slave_model i_sbg_slave_model (.scl_line_i(scl_line), .rises_o(rises));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task automatic summarize();
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Two half periods of 2(R+1) clocks per scl period, 16 halves, +1 sampling edge
    function automatic int op_cycles(int rv);
        return 32 * (rv + 1) + 1;
    endfunction
    function automatic logic [31:0] modes(logic i2c, logic b7);
        return {29'h0, i2c & ~b7, ~i2c & b7, i2c};
    endfunction
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int a = 0; a <= 16; a += 4) begin
            bus(a[7:0], 1'b0, 32'h0);
            chk(q, 32'h0);
        end
        bus(STATUS_OFS, 1'b1, 32'hffffffff);
        bus(STATUS_OFS, 1'b0, 32'h0);
        chk(q, 32'hc0);
        for (int m = 0; m < 4; m++) begin
            bus(CTRL_OFS, 1'b1, {30'h0, m[0], 1'b1});
            bus(STATUS_OFS, 1'b1, {24'h0, m[1], m[0], 6'h0});
            repeat (2) @(posedge clock_i);
            chk({slew_ctrl_en_o, sample_at_end_o, clk_edge_sel_o}, modes(m[0], m[1]));
        end
        for (int k = 0; k < 6; k++) begin
            r = 3 + {$random(seed)} % 10;
            bus(RELOAD_OFS, 1'b1, r);
            bus(RELOAD_OFS, 1'b0, 32'h0);
            chk(q, r);
            bus(CTRL_OFS, 1'b1, {30'h0, k[0], 1'b1});
            base = rises;
            lvl = scl_o;
            bus(SHBUF_OFS, 1'b1, $random(seed));
            n = 0;
            if (k == 1) begin
                bus(SHBUF_OFS, 1'b1, 32'h5a);
                bus(CTRL_OFS, 1'b0, 32'h0);
                chk(q, 32'h7);
                n = 6;
            end
            do begin
                @(posedge clock_i);
                n++;
            end while (busy_o === 1'b1 && n < 9000);
            chk(n, op_cycles(r));
            chk(rises - base, 8);
            repeat (8) @(posedge clock_i);
            chk(scl_o, lvl);
        end
        bus(RELOAD_OFS, 1'b1, 32'h14);
        bus(CTRL_OFS, 1'b1, 32'h0);
        bus(SHBUF_OFS, 1'b1, 32'h3c);
        repeat (3) @(posedge clock_i);
        chk(busy_o, 1'b0);
        bus(CTRL_OFS, 1'b1, 32'h1);
        bus(SHBUF_OFS, 1'b1, 32'h3c);
        // Abort inside the low half: the clock must stay low, not snap back high
        repeat (50) @(posedge clock_i);
        bus(CTRL_OFS, 1'b1, 32'h0);
        repeat (6) @(posedge clock_i);
        chk({busy_o, scl_o}, 2'b00);
        summarize();
    end
endmodule
